//--- serr_consts.vh
// Purpose: Constants of the sync error indication and reporting block
// Assumes: 250 MHz mclk_i, Avalon-MM word addressing
// Notes: Register offsets below, then fields, resets, timing
`ifndef SERR_CONSTS_VH
`define SERR_CONSTS_VH
// Register word indices (byte address is four times the index)
`define SERR_REG_CFG_PEND 3'h0
`define SERR_REG_CFG_ACT 3'h1
`define SERR_REG_TIMES 3'h2
`define SERR_REG_IRQ_STAT 3'h3
`define SERR_REG_IRQ_EN 3'h4
`define SERR_REG_IRQ_CLR 3'h5
`define SERR_REG_AL_CODE 3'h6
`define SERR_REG_LIVE 3'h7
// Field positions
`define SERR_CFG_PER_MSB 15
`define SERR_CFG_CNT_LSB 16
`define SERR_CFG_CNT_MSB 20
`define SERR_CFG_INONLY 24
`define SERR_TIM_COMM_LSB 16
// Reset values
`define SERR_CFG_RST 32'h0000_03E8
`define SERR_TIMES_RST 32'h0064_0064
// Valid sync period range in microseconds
`define SERR_PER_MIN 16'h007D
`define SERR_PER_MAX 16'h2710
// Event bits
`define SERR_EV_FREQ 0
`define SERR_EV_START 1
`define SERR_EV_OP 2
`define SERR_EV_COMM 3
`define SERR_EV_SENS 4
`define SERR_EV_AL 5
`define SERR_EV_W 6
// Emergency codes: standard parameter error and vendor-specific range
`define SERR_EMCY_FREQ 16'h6320
`define SERR_EMCY_SENS 16'hFF01
// AL status codes of the fieldbus group
`define SERR_AL_SYNC 16'h001A
`define SERR_AL_FATAL_SYNC 16'h002C
`define SERR_AL_BAD_CYCLE 16'h0035
// Timing
`define SERR_CLK_NS 4
`define SERR_US_NS 1000
`define SERR_CYC_PER_US 250
`define SERR_US_PER_MS 1000
`define SERR_BLINK_MS 200
`define SERR_FLASH_ON_MS 200
`define SERR_FLASH_OFF_MS 1000
`endif

//--- serr_timeout.v
// Purpose: Microsecond timeout, expires when armed and not kicked for limit
// Assumes: tick_i is a one-cycle pulse each microsecond
// Notes: Expiry is a level that drops when the timer is disarmed or kicked
`timescale 1ns/1ps
module serr_timeout (
  input wire mclk_i,
  input wire reset_i,
  input wire tick_i,
  input wire arm_i,
  input wire kick_i,
  input wire [15:0] limit_i,
  output reg expire_o
);
  reg [15:0] cnt_q;

  always @(posedge mclk_i) begin
    if (reset_i) begin
      cnt_q <= 16'h0000;
      expire_o <= 1'b0;
    end else begin
      if (!arm_i || kick_i) begin
        cnt_q <= 16'h0000;
      end else if (tick_i && cnt_q != limit_i) begin
        cnt_q <= cnt_q + 16'h0001;
      end
      expire_o <= arm_i & ~kick_i & (cnt_q == limit_i);
    end
  end
endmodule

//--- serr_blink.v
// Purpose: Indicator pattern source, blink and single flash levels
// Assumes: tick_i is a one-cycle pulse each microsecond
// Notes: Both patterns start with the lamp on after reset
`timescale 1ns/1ps
`include "serr_consts.vh"
module serr_blink (
  input wire mclk_i,
  input wire reset_i,
  input wire tick_i,
  output reg blink_o,
  output reg flash_o
);
  reg [9:0] us_q;
  reg [10:0] ms_q;
  reg [7:0] bl_q;
  wire ms_tick;

  assign ms_tick = tick_i && (us_q == 10'd`SERR_US_PER_MS - 10'd1);

  always @(posedge mclk_i) begin
    if (reset_i) begin
      us_q <= 10'h000;
      ms_q <= 11'h000;
      bl_q <= 8'h00;
      blink_o <= 1'b1;
      flash_o <= 1'b1;
    end else begin
      if (ms_tick) begin
        us_q <= 10'h000;
      end else if (tick_i) begin
        us_q <= us_q + 10'h001;
      end
      if (ms_tick) begin
        if (bl_q == 8'd`SERR_BLINK_MS - 8'd1) begin
          bl_q <= 8'h00;
          blink_o <= ~blink_o;
        end else begin
          bl_q <= bl_q + 8'h01;
        end
        if (ms_q == 11'd`SERR_FLASH_ON_MS + 11'd`SERR_FLASH_OFF_MS - 11'd1) begin
          ms_q <= 11'h000;
        end else begin
          ms_q <= ms_q + 11'h001;
        end
      end
      flash_o <= (ms_q < 11'd`SERR_FLASH_ON_MS);
    end
  end
endmodule

//--- serr_top.v
// Purpose: Sync fault detection, indicators and error reporting of the slave
// Assumes: One 250 MHz clock; sync pulse pin is asynchronous
// Notes: reset_i is the power cycle; por_i also wipes the retained settings
//
// Our own choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
`include "serr_consts.vh"
module serr_top (
  input wire mclk_i,
  input wire reset_i,
  input wire por_i,
  input wire [2:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  output reg [31:0] avs_readdata_o,
  output reg avs_waitrequest_o,
  output reg irq_o,
  input wire dc_sync_pulse_zero_i,
  input wire sync_active_i,
  input wire frame_ok_i,
  input wire cycle_i,
  input wire restart_i,
  input wire [4:0] detected_count_i,
  input wire run_norm_i,
  input wire err_norm_i,
  input wire ecat_comm_err_i,
  input wire [15:0] ecat_err_code_i,
  output reg power_indicator_o,
  output reg run_led_o,
  output reg err_led_o,
  output reg ss_red_o,
  output reg [7:0] txpdo_status_o,
  output reg txpdo_strobe_o,
  output reg emcy_valid_o,
  output reg [15:0] emcy_code_o,
  input wire emcy_ready_i,
  output reg [15:0] al_status_code_o,
  output reg al_err_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  reg [31:0] cfg_pend_q;
  reg [31:0] cfg_act_q;
  reg [31:0] times_q;
  reg [`SERR_EV_W-1:0] irq_stat_q;
  reg [`SERR_EV_W-1:0] irq_en_q;
  reg [7:0] pre_q;
  reg tick_q;
  reg sp_m_q;
  reg sp_s_q;
  reg sp_p_q;
  reg seen_q;
  reg freq_err_q;
  reg start_err_q;
  reg op_err_q;
  reg comm_err_q;
  reg sens_q;
  reg [1:0] emcy_pend_q;
  reg [31:0] rmux;
  reg [31:0] wmask;
  reg [`SERR_EV_W-1:0] ev;
  reg run_d;
  reg err_d;
  wire req;
  wire wr_en;
  wire sp_edge;
  wire [15:0] per;
  wire per_bad;
  wire input_only;
  wire start_exp;
  wire op_exp;
  wire comm_exp;
  wire sens_d;
  wire blink;
  wire flash;
  wire freq_rise;
  wire start_rise;
  wire op_rise;
  wire comm_rise;
  wire sens_rise;
  wire [1:0] launch;

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait cycle, then waitrequest low for one cycle
  assign req = avs_read_i | avs_write_i;
  assign wr_en = avs_write_i & ~avs_waitrequest_o;

  always @* begin
    wmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
             {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  end

  always @* begin
    rmux = 32'h0000_0000;
    case (avs_address_i)
      `SERR_REG_CFG_PEND: rmux = cfg_pend_q;
      `SERR_REG_CFG_ACT: rmux = cfg_act_q;
      `SERR_REG_TIMES: rmux = times_q;
      `SERR_REG_IRQ_STAT: rmux = {26'h000_0000, irq_stat_q};
      `SERR_REG_IRQ_EN: rmux = {26'h000_0000, irq_en_q};
      `SERR_REG_AL_CODE: rmux = {15'h0000, al_err_o, al_status_code_o};
      `SERR_REG_LIVE: rmux = {11'h000, detected_count_i, 8'h00, txpdo_status_o};
      default: rmux = 32'h0000_0000;
    endcase
  end

  always @(posedge mclk_i) begin
    if (reset_i || por_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0000_0000;
    end else begin
      avs_waitrequest_o <= ~(req & avs_waitrequest_o);
      if (req && avs_waitrequest_o) begin
        avs_readdata_o <= avs_read_i ? rmux : 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Settings: pending copy survives reset_i, active copy loads only then
  // Retaining the pending word across reset_i stands in for non-volatile store
  always @(posedge mclk_i) begin
    if (por_i) begin
      cfg_pend_q <= `SERR_CFG_RST;
    end else if (wr_en && avs_address_i == `SERR_REG_CFG_PEND) begin
      cfg_pend_q <= (cfg_pend_q & ~wmask) | (avs_writedata_i & wmask);
    end
  end

  always @(posedge mclk_i) begin
    if (por_i) begin
      cfg_act_q <= `SERR_CFG_RST;
    end else if (reset_i) begin
      cfg_act_q <= cfg_pend_q;
    end
  end

  always @(posedge mclk_i) begin
    if (reset_i || por_i) begin
      times_q <= `SERR_TIMES_RST;
      irq_en_q <= 6'h00;
    end else if (wr_en) begin
      if (avs_address_i == `SERR_REG_TIMES) begin
        times_q <= (times_q & ~wmask) | (avs_writedata_i & wmask);
      end
      if (avs_address_i == `SERR_REG_IRQ_EN && avs_byteenable_i[0]) begin
        irq_en_q <= avs_writedata_i[`SERR_EV_W-1:0];
      end
    end
  end

  assign per = cfg_act_q[`SERR_CFG_PER_MSB:0];
  assign input_only = cfg_act_q[`SERR_CFG_INONLY];

  ////////////////////////////////////////////////////////////////////////////
  // Microsecond tick and sync pulse synchroniser
  always @(posedge mclk_i) begin
    if (reset_i || por_i) begin
      pre_q <= 8'h00;
      tick_q <= 1'b0;
      sp_m_q <= 1'b0;
      sp_s_q <= 1'b0;
      sp_p_q <= 1'b0;
    end else begin
      tick_q <= (pre_q == 8'd`SERR_CYC_PER_US - 8'd1);
      pre_q <= (pre_q == 8'd`SERR_CYC_PER_US - 8'd1) ? 8'h00 : pre_q + 8'h01;
      sp_m_q <= dc_sync_pulse_zero_i;
      sp_s_q <= sp_m_q;
      sp_p_q <= sp_s_q;
    end
  end

  assign sp_edge = sp_s_q & ~sp_p_q;

  ////////////////////////////////////////////////////////////////////////////
  // Sync supervision
  assign per_bad = (per < `SERR_PER_MIN) || (per > `SERR_PER_MAX);

  serr_timeout u_start_to (
    .mclk_i(mclk_i),
    .reset_i(reset_i | por_i),
    .tick_i(tick_q),
    .arm_i(sync_active_i & ~seen_q & ~per_bad),
    .kick_i(sp_edge),
    .limit_i(times_q[15:0]),
    .expire_o(start_exp)
  );

  serr_timeout u_op_to (
    .mclk_i(mclk_i),
    .reset_i(reset_i | por_i),
    .tick_i(tick_q),
    .arm_i(sync_active_i & seen_q),
    .kick_i(sp_edge),
    .limit_i(times_q[31:`SERR_TIM_COMM_LSB]),
    .expire_o(op_exp)
  );

  // An input-only unit has no output data to time out on
  serr_timeout u_comm_to (
    .mclk_i(mclk_i),
    .reset_i(reset_i | por_i),
    .tick_i(tick_q),
    .arm_i(sync_active_i & ~input_only),
    .kick_i(frame_ok_i),
    .limit_i(times_q[31:`SERR_TIM_COMM_LSB]),
    .expire_o(comm_exp)
  );

  // Errors stay latched until the master orders a restart; a new fault wins
  always @(posedge mclk_i) begin
    if (reset_i || por_i) begin
      seen_q <= 1'b0;
      freq_err_q <= 1'b0;
      start_err_q <= 1'b0;
      op_err_q <= 1'b0;
      comm_err_q <= 1'b0;
    end else begin
      seen_q <= sync_active_i & (seen_q | sp_edge);
      freq_err_q <= (sync_active_i & per_bad) | (freq_err_q & ~restart_i);
      start_err_q <= start_exp | (start_err_q & ~restart_i);
      op_err_q <= op_exp | (op_err_q & ~restart_i);
      comm_err_q <= comm_exp | (comm_err_q & ~restart_i);
    end
  end

  assign freq_rise = sync_active_i & per_bad & ~freq_err_q;
  assign start_rise = start_exp & ~start_err_q;
  assign op_rise = op_exp & ~op_err_q;
  assign comm_rise = comm_exp & ~comm_err_q;

  ////////////////////////////////////////////////////////////////////////////
  // Sensor count check, dummies already counted in the setting
  assign sens_d = cfg_act_q[`SERR_CFG_CNT_MSB:`SERR_CFG_CNT_LSB] != detected_count_i;
  assign sens_rise = sens_d & ~sens_q;

  ////////////////////////////////////////////////////////////////////////////
  // Indicators
  serr_blink u_blink (
    .mclk_i(mclk_i),
    .reset_i(reset_i | por_i),
    .tick_i(tick_q),
    .blink_o(blink),
    .flash_o(flash)
  );

  always @* begin
    run_d = run_norm_i;
    err_d = err_norm_i;
    if (freq_err_q) begin
      run_d = blink;
      err_d = blink;
    end else if (start_err_q) begin
      run_d = blink;
      err_d = flash;
    end else if (op_err_q || comm_err_q) begin
      run_d = flash;
      err_d = flash;
    end
  end

  always @(posedge mclk_i) begin
    if (reset_i || por_i) begin
      power_indicator_o <= 1'b0;
      run_led_o <= 1'b0;
      err_led_o <= 1'b0;
      ss_red_o <= 1'b0;
      sens_q <= 1'b0;
    end else begin
      power_indicator_o <= 1'b1;
      run_led_o <= run_d;
      err_led_o <= err_d;
      sens_q <= sens_d;
      ss_red_o <= sens_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-cycle status into the TxPDO
  always @(posedge mclk_i) begin
    if (reset_i || por_i) begin
      txpdo_status_o <= 8'h00;
      txpdo_strobe_o <= 1'b0;
    end else begin
      txpdo_strobe_o <= cycle_i;
      if (cycle_i) begin
        txpdo_status_o <= {2'b00, al_err_o, sens_q, comm_err_q, op_err_q,
                           start_err_q, freq_err_q};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Emergency messages, held until the master side accepts
  assign launch = (!emcy_valid_o && emcy_pend_q[0]) ? 2'b01 :
                  (!emcy_valid_o && emcy_pend_q[1]) ? 2'b10 : 2'b00;

  always @(posedge mclk_i) begin
    if (reset_i || por_i) begin
      emcy_pend_q <= 2'b00;
      emcy_valid_o <= 1'b0;
      emcy_code_o <= 16'h0000;
    end else begin
      emcy_pend_q <= (emcy_pend_q & ~launch) | {sens_rise, freq_rise};
      if (launch[0]) begin
        emcy_valid_o <= 1'b1;
        emcy_code_o <= `SERR_EMCY_FREQ;
      end else if (launch[1]) begin
        emcy_valid_o <= 1'b1;
        emcy_code_o <= `SERR_EMCY_SENS;
      end else if (emcy_ready_i) begin
        emcy_valid_o <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AL status: group codes for sync faults, bus error code passed through; first error kept; a new error beats restart
  always @(posedge mclk_i) begin
    if (reset_i || por_i) begin
      al_status_code_o <= 16'h0000;
      al_err_o <= 1'b0;
    end else if (!al_err_o || restart_i) begin
      if (ecat_comm_err_i) begin
        al_err_o <= 1'b1;
        al_status_code_o <= ecat_err_code_i;
      end else if (freq_rise) begin
        al_err_o <= 1'b1;
        al_status_code_o <= `SERR_AL_BAD_CYCLE;
      end else if (start_rise || op_rise) begin
        al_err_o <= 1'b1;
        al_status_code_o <= `SERR_AL_FATAL_SYNC;
      end else if (comm_rise) begin
        al_err_o <= 1'b1;
        al_status_code_o <= `SERR_AL_SYNC;
      end else begin
        al_err_o <= 1'b0;
        al_status_code_o <= 16'h0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status: set wins over a same-cycle clear
  always @* begin
    ev = 6'h00;
    ev[`SERR_EV_FREQ] = freq_rise;
    ev[`SERR_EV_START] = start_rise;
    ev[`SERR_EV_OP] = op_rise;
    ev[`SERR_EV_COMM] = comm_rise;
    ev[`SERR_EV_SENS] = sens_rise;
    ev[`SERR_EV_AL] = ecat_comm_err_i;
  end

  always @(posedge mclk_i) begin
    if (reset_i || por_i) begin
      irq_stat_q <= 6'h00;
      irq_o <= 1'b0;
    end else begin
      if (wr_en && avs_address_i == `SERR_REG_IRQ_CLR && avs_byteenable_i[0]) begin
        irq_stat_q <= (irq_stat_q & ~avs_writedata_i[`SERR_EV_W-1:0]) | ev;
      end else begin
        irq_stat_q <= irq_stat_q | ev;
      end
      irq_o <= |(irq_stat_q & irq_en_q);
    end
  end

endmodule

//--- serr_top_props.sv
// Purpose: Port-level property checker for serr_top
// Assumes: One clock domain; reset_i and por_i both synchronous, active high
// Notes: Run and error lamp checks wait until an error has stood two cycles
`timescale 1ns/1ps
module serr_top_props (
  input wire mclk_i,
  input wire reset_i,
  input wire por_i,
  input wire cycle_i,
  input wire restart_i,
  input wire emcy_ready_i,
  input wire ecat_comm_err_i,
  input wire [4:0] detected_count_i,
  input wire power_indicator_o,
  input wire run_led_o,
  input wire err_led_o,
  input wire ss_red_o,
  input wire txpdo_strobe_o,
  input wire emcy_valid_o,
  input wire [15:0] emcy_code_o,
  input wire [15:0] al_status_code_o,
  input wire al_err_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (reset_i || por_i);
  ////////////////////////////////////////////////////////////////
  sequence s_emcy_stall;
    emcy_valid_o && !emcy_ready_i;
  endsequence
  sequence s_new_comm_err;
    ecat_comm_err_i && !al_err_o && !restart_i;
  endsequence
  // Error must have stood two cycles so the lamp mux has caught up
  sequence s_err_held(c);
    al_err_o && $past(al_err_o, 2) && al_status_code_o == c;
  endsequence
  ////////////////////////////////////////////////////////////////
  chk_freq_both_blink:
    assert property (s_err_held(16'h0035) |-> run_led_o == err_led_o)
    else $error("run and error lamps differ on sync frequency fault");
  chk_comm_both_flash:
    assert property (s_err_held(16'h001A) |-> run_led_o == err_led_o)
    else $error("run and error lamps differ on comm sync fault");
  chk_sensor_steady:
    assert property ((power_indicator_o && $stable(detected_count_i)) [*4]
      |-> $stable(ss_red_o))
    else $error("sensor lamp moved without a count change");
  chk_txpdo_each_cycle:
    assert property (cycle_i && power_indicator_o |=> txpdo_strobe_o)
    else $error("no status strobe after a cycle");
  chk_emcy_on_mismatch:
    assert property ($rose(ss_red_o) |-> ##[0:4] emcy_valid_o)
    else $error("no emergency after sensor mismatch");
  chk_emcy_holds:
    assert property (s_emcy_stall |=> emcy_valid_o && $stable(emcy_code_o))
    else $error("emergency dropped or changed before acceptance");
  chk_emcy_code_range:
    assert property (emcy_valid_o |-> emcy_code_o == 16'h6320 || emcy_code_o == 16'hFF01)
    else $error("emergency code outside the chosen set");
  chk_al_on_comm:
    assert property (s_new_comm_err |-> ##[1:2] al_err_o)
    else $error("bus error did not set the status code");
  chk_al_code_known:
    assert property ($rose(al_err_o) |-> al_status_code_o inside
      {16'h001A, 16'h002C, 16'h0035} || $past(ecat_comm_err_i)
      || $past(ecat_comm_err_i, 2))
    else $error("status code set without a known cause");
endmodule
bind serr_top serr_top_props serr_top_props_i (
  .mclk_i(mclk_i),
  .reset_i(reset_i),
  .por_i(por_i),
  .cycle_i(cycle_i),
  .restart_i(restart_i),
  .emcy_ready_i(emcy_ready_i),
  .ecat_comm_err_i(ecat_comm_err_i),
  .detected_count_i(detected_count_i),
  .power_indicator_o(power_indicator_o),
  .run_led_o(run_led_o),
  .err_led_o(err_led_o),
  .ss_red_o(ss_red_o),
  .txpdo_strobe_o(txpdo_strobe_o),
  .emcy_valid_o(emcy_valid_o),
  .emcy_code_o(emcy_code_o),
  .al_status_code_o(al_status_code_o),
  .al_err_o(al_err_o)
);

//--- serr_master_model.sv
// Purpose: Fieldbus master stand-in: sync pulses, frames, cycles, emcy accept
// Assumes: 2 us communication cycle at 250 MHz
// Notes: Accept is delayed by the cycle phase, so emergencies often stall
`timescale 1ns/1ps
module serr_master_model (
  input wire mclk_i,
  input wire sync_en_i,
  input wire frame_en_i,
  input wire emcy_valid_i,
  output reg dc_sync_pulse_zero_o,
  output reg frame_ok_o,
  output reg cycle_o,
  output reg emcy_ready_o
);
  reg [9:0] tick_q = 10'h000;
  initial begin
    dc_sync_pulse_zero_o = 1'b0;
    frame_ok_o = 1'b0;
    cycle_o = 1'b0;
    emcy_ready_o = 1'b0;
  end
  always @(posedge mclk_i) begin
    tick_q <= (tick_q == 10'd499) ? 10'd0 : tick_q + 10'd1;
    dc_sync_pulse_zero_o <= sync_en_i && tick_q < 10'd20;
    frame_ok_o <= frame_en_i && tick_q == 10'd5;
    cycle_o <= tick_q == 10'd9;
    // Never two accepts in a row: one message per handshake
    emcy_ready_o <= emcy_valid_i && !emcy_ready_o && tick_q[1:0] == 2'd3;
  end
endmodule

//--- tb.sv
// Purpose: Self-checking bench for serr_top
// Assumes: 250 MHz clock; timeouts set to 5 us after each power cycle
// Notes: Expected emergencies are queued and matched at each accept
`timescale 1ns/1ps
module tb;
  reg mclk_i = 1'b0;
  reg reset_i = 1'b1;
  reg por_i = 1'b1;
  reg [2:0] avs_address_i = 3'h0;
  reg avs_read_i = 1'b0;
  reg avs_write_i = 1'b0;
  reg [31:0] avs_writedata_i = 32'h0000_0000;
  reg sync_active_i = 1'b0;
  reg restart_i = 1'b0;
  reg [4:0] detected_count_i = 5'h03;
  reg ecat_comm_err_i = 1'b0;
  reg [15:0] ecat_err_code_i = 16'h0000;
  reg sync_en = 1'b0;
  reg frame_en = 1'b0;
  wire [31:0] avs_readdata_o;
  wire avs_waitrequest_o, irq_o, dc_sync_pulse_zero_i, frame_ok_i, cycle_i, emcy_ready_i;
  wire power_indicator_o, run_led_o, err_led_o, ss_red_o, txpdo_strobe_o, emcy_valid_o;
  wire al_err_o;
  wire [7:0] txpdo_status_o;
  wire [15:0] emcy_code_o, al_status_code_o;
  wire [8:0] obs = {irq_o, ss_red_o, al_err_o, txpdo_status_o[5:0]};
  integer err_total = 0;
  integer cmp_count = 0;
  integer cyc = 0;
  integer n, seed_v;
  reg [31:0] rd;
  reg [15:0] code_v;
  integer exp_q[$];
  ////////////////////////////////////////////////////////////////
  serr_top serr_top_i (.mclk_i(mclk_i), .reset_i(reset_i), .por_i(por_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hF),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o),
    .dc_sync_pulse_zero_i(dc_sync_pulse_zero_i), .sync_active_i(sync_active_i),
    .frame_ok_i(frame_ok_i), .cycle_i(cycle_i), .restart_i(restart_i),
    .detected_count_i(detected_count_i), .run_norm_i(1'b1), .err_norm_i(1'b0),
    .ecat_comm_err_i(ecat_comm_err_i), .ecat_err_code_i(ecat_err_code_i),
    .power_indicator_o(power_indicator_o), .run_led_o(run_led_o), .err_led_o(err_led_o),
    .ss_red_o(ss_red_o), .txpdo_status_o(txpdo_status_o), .txpdo_strobe_o(txpdo_strobe_o),
    .emcy_valid_o(emcy_valid_o), .emcy_code_o(emcy_code_o), .emcy_ready_i(emcy_ready_i),
    .al_status_code_o(al_status_code_o), .al_err_o(al_err_o));
  serr_master_model serr_master_model_i (.mclk_i(mclk_i), .sync_en_i(sync_en),
    .frame_en_i(frame_en), .emcy_valid_i(emcy_valid_o),
    .dc_sync_pulse_zero_o(dc_sync_pulse_zero_i), .frame_ok_o(frame_ok_i),
    .cycle_o(cycle_i), .emcy_ready_o(emcy_ready_i));
  ////////////////////////////////////////////////////////////////
  task cmp(input [8*12:1] nm, input [31:0] exp, input [31:0] got);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("BAD %0s exp %h got %h", nm, exp, got);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
        $display("Regression OK");
      end else begin
        $display("Regression broken");
      end
      $finish;
    end
  endtask
  task bus(input [2:0] a, input w, input [31:0] d);
    begin
      @(posedge mclk_i);
      avs_address_i <= a;
      avs_write_i <= w;
      avs_read_i <= !w;
      avs_writedata_i <= d;
      @(posedge mclk_i);
      while (avs_waitrequest_o !== 1'b0) @(posedge mclk_i);
      rd = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
    end
  endtask
  task wait_bit(input integer b, input v);
    begin
      n = 0;
      while (obs[b] !== v && n < 4000) begin
        @(posedge mclk_i);
        n = n + 1;
      end
      cmp("wait flag", 1, n < 4000);
    end
  endtask
  task restart;
    begin
      @(posedge mclk_i);
      restart_i <= 1'b1;
      @(posedge mclk_i);
      restart_i <= 1'b0;
    end
  endtask
  // Reset keeps the staged settings; timeouts and enables are written again
  task power_cycle(input [31:0] act);
    begin
      @(posedge mclk_i);
      reset_i <= 1'b1;
      @(posedge mclk_i);
      reset_i <= 1'b0;
      bus(3'h2, 1'b1, 32'h0005_0005);
      bus(3'h4, 1'b1, 32'h0000_003F);
      bus(3'h1, 1'b0, 0);
      cmp("act load", act, rd);
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    forever #2 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    cyc = cyc + 1;
    if (emcy_valid_o === 1'b1 && emcy_ready_i === 1'b1) begin
      if (exp_q.size() == 0) cmp("emcy extra", 0, 1);
      else cmp("emcy code", exp_q.pop_front(), emcy_code_o);
    end
    if (cyc == 60000) begin
      err_total = err_total + 1;
      give_verdict;
    end
  end
  initial begin
    seed_v = $urandom(32'hbe17_96da);
    // Cold settings hold no sensors while three are fitted: one mismatch message
    exp_q.push_back(32'hFF01);
    repeat (3) @(posedge mclk_i);
    reset_i <= 1'b0;
    por_i <= 1'b0;
    bus(3'h2, 1'b0, 0);
    cmp("times rst", 32'h0064_0064, rd);
    bus(3'h5, 1'b0, 0);
    cmp("clr read", 0, rd);
    bus(3'h0, 1'b1, 32'h0003_0064);
    bus(3'h1, 1'b0, 0);
    cmp("act hold", 32'h0000_03E8, rd);
    power_cycle(32'h0003_0064);
    $display("test settings done");
    exp_q.push_back(32'h6320);
    sync_active_i <= 1'b1;
    wait_bit(6, 1);
    cmp("al freq", 16'h0035, al_status_code_o);
    wait_bit(0, 1);
    wait_bit(8, 1);
    exp_q.push_back(32'hFF01);
    detected_count_i <= 5'(4 + $urandom % 28);
    wait_bit(7, 1);
    wait_bit(4, 1);
    detected_count_i <= 5'h03;
    wait_bit(7, 0);
    n = 0;
    while (exp_q.size() != 0 && n < 2000) begin
      @(posedge mclk_i);
      n = n + 1;
    end
    cmp("emcy drain", 0, exp_q.size());
    $display("test frequency done");
    sync_active_i <= 1'b0;
    restart;
    bus(3'h0, 1'b1, 32'h0003_03E8);
    power_cycle(32'h0003_03E8);
    sync_active_i <= 1'b1;
    wait_bit(6, 1);
    cmp("start time", 1, n >= 1000 && n <= 1260);
    cmp("al start", 16'h002C, al_status_code_o);
    wait_bit(1, 1);
    cmp("err lamp", 1, err_led_o);
    bus(3'h4, 1'b1, 0);
    wait_bit(8, 0);
    sync_active_i <= 1'b0;
    restart;
    bus(3'h5, 1'b1, 32'h0000_003F);
    bus(3'h3, 1'b0, 0);
    cmp("stat clr", 0, rd);
    $display("test start done");
    sync_en <= 1'b1;
    frame_en <= 1'b1;
    sync_active_i <= 1'b1;
    repeat (3000) @(posedge mclk_i);
    cmp("no err", 0, al_err_o);
    frame_en <= 1'b0;
    wait_bit(6, 1);
    cmp("al comm", 16'h001A, al_status_code_o);
    wait_bit(3, 1);
    sync_en <= 1'b0;
    wait_bit(2, 1);
    $display("test loss done");
    sync_active_i <= 1'b0;
    restart;
    code_v = 16'h0036 + 16'($urandom % 200);
    ecat_comm_err_i <= 1'b1;
    ecat_err_code_i <= code_v;
    @(posedge mclk_i);
    ecat_comm_err_i <= 1'b0;
    wait_bit(6, 1);
    cmp("al ecat", code_v, al_status_code_o);
    restart;
    wait_bit(6, 0);
    $display("test status done");
    bus(3'h0, 1'b1, 32'h0103_03E8);
    power_cycle(32'h0103_03E8);
    sync_en <= 1'b1;
    sync_active_i <= 1'b1;
    repeat (3000) @(posedge mclk_i);
    cmp("inonly comm", 0, txpdo_status_o[3]);
    cmp("inonly op", 0, al_err_o);
    $display("test input only done");
    give_verdict;
  end
endmodule
